// [design/li_charge_seq.v]
// lithium multi-step charge sequencer with status display and pack authentication
// Operation
// - reset enters pending; stays there until a pack is detected with supply valid
// - pending goes to qualification (to authentication first when enabled) only with pack present and supply valid
// - qualification goes to suspend when temperature outside initiation window
// - qualification goes precharge when voltage below initiation minimum, temperature in window
// - qualification goes current regulation when voltage above minimum but not above recharge threshold, temperature in window
// - qualification goes complete when voltage above recharge threshold, temperature in window
// - precharge applies the configured low precharge current
// - precharge goes current regulation when voltage above minimum, temperature in window
// - precharge timeout with low voltage or temperature out of window goes suspend
// - every charging or idle state returns to pending when pack absent
// - suspend applies no charge current
// - suspend goes precharge when temperature in window, voltage below recharge threshold, no authentication failure
// - current regulation charges at regulation current, limited by regulation voltage
// - current regulation goes voltage regulation at regulation voltage, below charging temp max
// - current regulation suspends on over voltage or temperature out of limits
// - current regulation suspends when its time limit is exceeded
// - voltage regulation completes when current tapers with voltage at regulation
// - voltage regulation suspends on over voltage, over temperature or timeout
// - complete stops charging; restarts via pending on removal or low voltage
// - two indicator outputs with per-state patterns and flash rates
// - when enabled send 32-bit challenge; pack returns response for validation
// - each indicator has one pattern byte per charger state
// - temperatures compared in the encoded one-byte form
`include "li_charge_consts.vh"

module li_charge_seq
#(
  parameter [31:0] MINUTE_CYCLES = `MINUTE_CYCLES,
  parameter [23:0] PHASE_CYCLES  = `PHASE_DEFAULT,
  parameter [15:0] AUTH_TIMEOUT  = `AUTH_TIMEOUT_DEF
)
(
  // clock and reset
  input  wire                ref_clk_i,
  input  wire                resetn_i,
  // presence and supply
  input  wire                battery_present_i,
  input  wire                supply_valid_i,
  // voltage comparisons from front end
  input  wire                volt_below_init_min_i,
  input  wire                volt_above_recharge_i,
  input  wire                volt_at_regulation_i,
  input  wire                volt_above_charge_max_i,
  // current comparison
  input  wire                current_at_taper_i,
  // encoded temperature and limits
  input  wire [7:0]          battery_temp_i,
  input  wire [7:0]          init_temp_min_i,
  input  wire [7:0]          init_temp_max_i,
  input  wire [7:0]          charging_temp_max_i,
  // time limits in minutes
  input  wire [7:0]          precharge_time_i,
  input  wire [7:0]          current_reg_time_i,
  input  wire [7:0]          voltage_reg_time_i,
  // display patterns, one byte per state, state 0 in low byte
  input  wire [55:0]         pattern_a_i,
  input  wire [55:0]         pattern_b_i,
  // authentication
  input  wire                auth_enable_i,
  input  wire [31:0]         auth_seed_i,
  input  wire                response_valid_i,
  input  wire                response_ok_i,
  output reg                 challenge_valid_o,
  output reg  [31:0]         challenge_o,
  output reg                 auth_fail_o,
  // charge action and display
  output reg  [1:0]          charge_action_o,
  output reg  [2:0]          charge_state_o,
  output reg                 status_indicator_a_o,
  output reg                 status_indicator_b_o
);

  // -----------------------------------------------------------------
  // states
  // -----------------------------------------------------------------
  localparam [7:0] S_PEND = 8'h01;
  localparam [7:0] S_AUTH = 8'h02;
  localparam [7:0] S_QUAL = 8'h04;
  localparam [7:0] S_PRE  = 8'h08;
  localparam [7:0] S_SUSP = 8'h10;
  localparam [7:0] S_CREG = 8'h20;
  localparam [7:0] S_REGULATION_VOLTAGE = 8'h40;
  localparam [7:0] S_DONE = 8'h80;

  reg  [7:0]  state_r;
  reg  [7:0]  state_nxt;
  reg  [31:0] tick_cnt_r;
  reg  [7:0]  minutes_r;
  reg  [23:0] phase_cnt_r;
  reg  [2:0]  phase_r;
  reg  [15:0] auth_cnt_r;
  reg  [31:0] lfsr_r;

  // encoded temperature window check
  function temp_in_window;
    input [7:0] t;
    input [7:0] lo;
    input [7:0] hi;
    begin
      temp_in_window = (t >= lo) && (t <= hi);
    end
  endfunction

  // limit check for timed states
  function time_over;
    input [7:0] mins;
    input [7:0] lim;
    begin
      time_over = (mins >= lim);
    end
  endfunction

  wire in_win    = temp_in_window(battery_temp_i, init_temp_min_i, init_temp_max_i);
  wire hot_chg   = (battery_temp_i >= charging_temp_max_i);
  wire entering  = (state_nxt != state_r);
  wire min_tick  = (tick_cnt_r == MINUTE_CYCLES - 32'h1);

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      S_PEND:
        if (battery_present_i && supply_valid_i)
          state_nxt = auth_enable_i ? S_AUTH : S_QUAL;
      S_AUTH:
        if (!battery_present_i)
          state_nxt = S_PEND;
        else if (response_valid_i && response_ok_i)
          state_nxt = S_QUAL;
        else if (response_valid_i || auth_cnt_r == AUTH_TIMEOUT)
          state_nxt = S_SUSP;
      S_QUAL:
        if (!battery_present_i)
          state_nxt = S_PEND;
        else if (!in_win)
          state_nxt = S_SUSP;
        else if (volt_above_recharge_i)
          state_nxt = S_DONE;
        else if (volt_below_init_min_i)
          state_nxt = S_PRE;
        else
          state_nxt = S_CREG;
      S_PRE:
        if (!battery_present_i)
          state_nxt = S_PEND;
        else if (!volt_below_init_min_i && in_win)
          state_nxt = S_CREG;
        else if (time_over(minutes_r, precharge_time_i))
          state_nxt = S_SUSP;
      S_SUSP:
        if (!battery_present_i)
          state_nxt = S_PEND;
        else if (in_win && !volt_above_recharge_i && !auth_fail_o)
          state_nxt = S_PRE;
      S_CREG:
        if (!battery_present_i)
          state_nxt = S_PEND;
        else if (volt_above_charge_max_i || !in_win)
          state_nxt = S_SUSP;
        else if (time_over(minutes_r, current_reg_time_i))
          state_nxt = S_SUSP;
        else if (volt_at_regulation_i && !hot_chg)
          state_nxt = S_REGULATION_VOLTAGE;
      S_REGULATION_VOLTAGE:
        if (!battery_present_i)
          state_nxt = S_PEND;
        else if (volt_above_charge_max_i || hot_chg
                 || time_over(minutes_r, voltage_reg_time_i))
          state_nxt = S_SUSP;
        else if (current_at_taper_i && volt_at_regulation_i)
          state_nxt = S_DONE;
      S_DONE:
        if (!battery_present_i || !volt_above_recharge_i)
          state_nxt = S_PEND;
      default:
        state_nxt = S_PEND;
    endcase
  end

  // -----------------------------------------------------------------
  // state register and minute timer
  // -----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_r    <= S_PEND;
      tick_cnt_r <= 32'h0;
      minutes_r  <= 8'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (entering)
      begin
        tick_cnt_r <= 32'h0;
        minutes_r  <= 8'h0;
      end
      else if (min_tick)
      begin
        tick_cnt_r <= 32'h0;
        if (minutes_r != 8'hFF)
          minutes_r <= minutes_r + 8'h1;
      end
      else
        tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // -----------------------------------------------------------------
  // authentication challenge
  // -----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lfsr_r            <= 32'h1;
      challenge_o       <= 32'h0;
      challenge_valid_o <= 1'b0;
      auth_cnt_r        <= 16'h0;
      auth_fail_o       <= 1'b0;
    end
    else
    begin
      lfsr_r <= {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
      challenge_valid_o <= 1'b0;
      if (state_r == S_PEND && state_nxt == S_AUTH)
      begin
        challenge_o       <= lfsr_r ^ auth_seed_i;
        challenge_valid_o <= 1'b1;
        auth_cnt_r        <= 16'h0;
      end
      else if (state_r == S_AUTH && auth_cnt_r != AUTH_TIMEOUT)
        auth_cnt_r <= auth_cnt_r + 16'h1;
      if (state_r == S_AUTH && state_nxt == S_SUSP)
        auth_fail_o <= 1'b1;
      else if (state_nxt == S_PEND)
        auth_fail_o <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // display phase and outputs
  // -----------------------------------------------------------------
  reg [2:0] st_idx;
  always @*
  begin
    case (state_nxt)
      S_PEND:  st_idx = `ST_PENDING;
      S_AUTH:  st_idx = `ST_QUAL;
      S_QUAL:  st_idx = `ST_QUAL;
      S_PRE:   st_idx = `ST_PRECHARGE;
      S_SUSP:  st_idx = `ST_SUSPEND;
      S_CREG:  st_idx = `ST_CURRENT_REG;
      S_REGULATION_VOLTAGE:  st_idx = `ST_VOLTAGE_REG;
      S_DONE:  st_idx = `ST_COMPLETE;
      default: st_idx = `ST_PENDING;
    endcase
  end

  wire [7:0] pat_a = pattern_a_i[st_idx*8 +: 8];
  wire [7:0] pat_b = pattern_b_i[st_idx*8 +: 8];

  // registered action, state code and indicators
  always @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase_cnt_r          <= 24'h0;
      phase_r              <= 3'h0;
      charge_action_o      <= `ACT_OFF;
      charge_state_o       <= `ST_PENDING;
      status_indicator_a_o <= 1'b0;
      status_indicator_b_o <= 1'b0;
    end
    else
    begin
      if (phase_cnt_r >= PHASE_CYCLES - 24'h1)
      begin
        phase_cnt_r <= 24'h0;
        phase_r     <= phase_r + 3'h1;
      end
      else
        phase_cnt_r <= phase_cnt_r + 24'h1;
      charge_state_o       <= st_idx;
      status_indicator_a_o <= pat_a[phase_r];
      status_indicator_b_o <= pat_b[phase_r];
      case (state_nxt)
        S_PRE:   charge_action_o <= `ACT_PRECHARGE;
        S_CREG:  charge_action_o <= `ACT_CURRENT_REG;
        S_REGULATION_VOLTAGE:  charge_action_o <= `ACT_VOLTAGE_REG;
        default: charge_action_o <= `ACT_OFF;
      endcase
    end
  end

endmodule // li_charge_seq

// [design/li_charge_consts.vh]
// constants for the lithium charge sequencer
`ifndef LI_CHARGE_CONSTS_VH
`define LI_CHARGE_CONSTS_VH

// clock rate and minute tick
`define CLK_HZ            10000000
`define SEC_PER_MIN       60
`define MINUTE_CYCLES     (`CLK_HZ * `SEC_PER_MIN)

// charge action codes
`define ACT_W             2
`define ACT_OFF           2'h0
`define ACT_PRECHARGE     2'h1
`define ACT_CURRENT_REG   2'h2
`define ACT_VOLTAGE_REG   2'h3

// state index for display pattern selection
`define ST_W              3
`define ST_PENDING        3'h0
`define ST_QUAL           3'h1
`define ST_PRECHARGE      3'h2
`define ST_SUSPEND        3'h3
`define ST_CURRENT_REG    3'h4
`define ST_VOLTAGE_REG    3'h5
`define ST_COMPLETE       3'h6

// display pattern: one byte, one bit shown per phase step
`define PAT_W             8
`define PHASE_W           3
`define PHASE_DEFAULT     24'h0F4240

// challenge width for pack authentication
`define CHAL_W            32
`define AUTH_TIMEOUT_DEF  16'h2710

`endif

// [tb/li_pack_model.sv]
// battery pack model: presence and challenge answer
module li_pack_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // bench commands
  input  wire logic insert_i,
  input  wire logic bad_i,
  // authentication link
  input  wire logic challenge_valid_i,
  output wire logic present_o,
  output logic      response_valid_o,
  output logic      response_ok_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_r;
  logic       busy_r;
  wire        due = busy_r && wait_r == 2'h3;
  assign present_o = insert_i;
  // answer a few cycles after the challenge; ok line toggles while idle
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      {busy_r, wait_r, response_valid_o, response_ok_o} <= 5'h00;
    end
    else
    begin
      response_valid_o <= due;
      response_ok_o    <= due ? !bad_i : ~response_ok_o;
      busy_r           <= challenge_valid_i || (busy_r && !due);
      wait_r           <= challenge_valid_i ? 2'h0 : wait_r + 2'h1;
    end
endmodule // li_pack_model

// [tb/li_charge_monitor.sv]
// port checker for the lithium charge sequencer
module li_charge_monitor (
  input wire logic       ref_clk_i,
  input wire logic       resetn_i,
  input wire logic       battery_present_i,
  input wire logic       supply_valid_i,
  input wire logic       volt_below_init_min_i,
  input wire logic       volt_above_recharge_i,
  input wire logic [7:0] battery_temp_i,
  input wire logic [7:0] init_temp_min_i,
  input wire logic [7:0] init_temp_max_i,
  input wire logic       auth_enable_i,
  input wire logic       challenge_valid_o,
  input wire logic [1:0] charge_action_o,
  input wire logic [2:0] charge_state_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // temperature window and plain qualification
  wire       pr  = battery_present_i;
  wire       win = battery_temp_i >= init_temp_min_i && battery_temp_i <= init_temp_max_i;
  wire       qok = charge_state_o == 3'h1 && pr && !auth_enable_i;
  wire       ar  = volt_above_recharge_i;
  wire [2:0] st  = charge_state_o;
  property p_start; st == 3'h0 && pr && supply_valid_i && !auth_enable_i |=> st == 3'h1; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_qsus; qok && !win |=> st == 3'h3; endproperty
  a_qsus: assert property (p_qsus) else $error("qualify to suspend");
  property p_qcmp; qok && win && ar |=> st == 3'h6; endproperty
  a_qcmp: assert property (p_qcmp) else $error("qualify to complete");
  property p_qpre; qok && win && !ar && volt_below_init_min_i |=> st == 3'h2; endproperty
  a_qpre: assert property (p_qpre) else $error("qualify to precharge");
  property p_qreg; qok && win && !ar && !volt_below_init_min_i |=> st == 3'h4; endproperty
  a_qreg: assert property (p_qreg) else $error("qualify to regulation");
  property p_gone; st >= 3'h2 && !pr |=> st == 3'h0; endproperty
  a_gone: assert property (p_gone) else $error("no return to pending");
  property p_act; charge_action_o == (st == 3'h2 ? 2'h1 : st == 3'h4 ? 2'h2 : st == 3'h5 ? 2'h3 : 2'h0); endproperty
  a_act: assert property (p_act) else $error("action mismatch");
  property p_chal; $rose(challenge_valid_o) |-> $past(auth_enable_i) && $past(st) == 3'h0 ##1 !challenge_valid_o;
  endproperty
  a_chal: assert property (p_chal) else $error("bad challenge pulse");
endmodule // li_charge_monitor

bind li_charge_seq li_charge_monitor u_mon (.*);

// [tb/li_charge_seq_tb_top.sv]
// self-checking bench for the lithium charge sequencer
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("Error %s exp %0h got %0h", n, e, g); end end
module li_charge_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_i, resetn_i, supply_valid_i, volt_below_init_min_i, volt_above_recharge_i, auth_enable_i;
  logic        volt_at_regulation_i, volt_above_charge_max_i, current_at_taper_i, insert, bad, battery_present_i;
  logic        response_valid_i, response_ok_i, challenge_valid_o, auth_fail_o, status_indicator_a_o;
  logic        status_indicator_b_o;
  logic [7:0]  battery_temp_i, init_temp_min_i, init_temp_max_i, charging_temp_max_i;
  logic [7:0]  precharge_time_i, current_reg_time_i, voltage_reg_time_i;
  logic [31:0] auth_seed_i, challenge_o, chal;
  logic [1:0]  charge_action_o;
  logic [2:0]  charge_state_o;
  logic [55:0] pattern_a_i = 56'hFF00FF5AFF00FF;
  logic [55:0] pattern_b_i = 56'h00FF00FF00FF00;
  int          fails = 0, comparisons = 0, cycles = 0, i, ones;
  li_charge_seq #(.MINUTE_CYCLES(32'hA), .PHASE_CYCLES(24'h4), .AUTH_TIMEOUT(16'h8)) u_dut (.*);
  li_pack_model u_pack (.clk_i(ref_clk_i), .resetn_i, .insert_i(insert), .bad_i(bad),
    .challenge_valid_i(challenge_valid_o), .present_o(battery_present_i), .response_valid_o(response_valid_i),
    .response_ok_o(response_ok_i));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // cut a hang short
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      test_done();
    end
  end
  function automatic [2:0] qual_nxt(input [7:0] t, lo, hi, input ar, bm);
    qual_nxt = (t < lo || t > hi) ? 3'h3 : ar ? 3'h6 : bm ? 3'h2 : 3'h4;
  endfunction
  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #10;
  endtask
  task automatic st_is(input [2:0] s);
    `CHK("charge_state_o", s, charge_state_o)
  endtask
  task automatic mv(input [2:0] s);
    step();
    st_is(s);
  endtask
  task automatic wait_st(input [2:0] s);
    for (int k = 0; k < 60 && charge_state_o !== s; k++)
      step();
    st_is(s);
  endtask
  task automatic enter(input [7:0] t, input ar, bm);
    battery_temp_i = t;
    volt_above_recharge_i = ar;
    volt_below_init_min_i = bm;
    insert = 1'b1;
    mv(3'h1);
    mv(qual_nxt(t, init_temp_min_i, init_temp_max_i, ar, bm));
  endtask
  task automatic pull;
    insert = 1'b0;
    step(2);
    st_is(3'h0);
    `CHK("status_indicator_a_o", 1'b1, status_indicator_a_o)
  endtask
  // main sequence
  initial
  begin
    {resetn_i, insert, bad, auth_enable_i, volt_at_regulation_i, volt_above_charge_max_i, current_at_taper_i} = 7'h00;
    {supply_valid_i, volt_below_init_min_i, volt_above_recharge_i, auth_seed_i} = 35'h0;
    {battery_temp_i, init_temp_min_i, init_temp_max_i, charging_temp_max_i} = 32'h6432AFC8;
    {precharge_time_i, current_reg_time_i, voltage_reg_time_i} = 24'hFFFFFF;
    i = $urandom(32'hd6bb);
    step(2);
    resetn_i = 1'b1;
    insert = 1'b1;
    step(3);
    st_is(3'h0);
    supply_valid_i = 1'b1;
    pull();
    for (i = 0; i < 40; i++)
    begin
      init_temp_min_i = 8'h28 + 8'($urandom % 40);
      init_temp_max_i = 8'h96 + 8'($urandom % 50);
      enter(8'($urandom), 1'($urandom), 1'($urandom));
      pull();
    end
    {init_temp_min_i, init_temp_max_i} = 16'h32AF;
    enter(8'h32, 1'b0, 1'b1);
    pull();
    enter(8'hB0, 1'b1, 1'b0);
    // one full flash period in suspend: ones follow the pattern byte
    ones = 0;
    for (int k = 0; k < 32; k++)
    begin
      step();
      ones += (status_indicator_a_o === 1'b1);
    end
    `CHK("status_indicator_a_o", $countones(pattern_a_i[31:24]) * 4, ones)
    pull();
    enter(8'h64, 1'b0, 1'b1);
    volt_below_init_min_i = 1'b0;
    mv(3'h4);
    volt_at_regulation_i = 1'b1;
    mv(3'h5);
    {current_at_taper_i, volt_above_recharge_i} = 2'h3;
    mv(3'h6);
    step(3);
    st_is(3'h6);
    volt_above_recharge_i = 1'b0;
    mv(3'h0);
    {current_at_taper_i, volt_at_regulation_i} = 2'h0;
    pull();
    enter(8'h64, 1'b0, 1'b0);
    volt_above_charge_max_i = 1'b1;
    mv(3'h3);
    {volt_above_charge_max_i, volt_below_init_min_i, precharge_time_i} = 10'h101;
    mv(3'h2);
    step(10);
    st_is(3'h2);
    mv(3'h3);
    pull();
    for (i = 0; i < 2; i++)
    begin
      {precharge_time_i, current_reg_time_i, voltage_reg_time_i} = i ? 24'hFFFF01 : 24'hFF01FF;
      volt_at_regulation_i = i[0];
      enter(8'h64, 1'b0, 1'b0);
      wait_st(3'h3);
      pull();
    end
    volt_at_regulation_i = 1'b0;
    enter(8'h64, 1'b0, 1'b0);
    resetn_i = 1'b0;
    step();
    st_is(3'h0);
    resetn_i = 1'b1;
    pull();
    auth_enable_i = 1'b1;
    auth_seed_i = $urandom;
    for (i = 0; i < 2; i++)
    begin
      bad = i[0];
      insert = 1'b1;
      step();
      `CHK("challenge_valid_o", 1'b1, challenge_valid_o)
      chal = challenge_o;
      wait_st(i ? 3'h3 : 3'h4);
      step(2);
      `CHK("challenge_o", chal, challenge_o)
      `CHK("auth_fail_o", i[0], auth_fail_o)
      `CHK("status_indicator_b_o", i[0], status_indicator_b_o)
      pull();
    end
    `CHK("auth_fail_o", 1'b0, auth_fail_o)
    test_done();
  end
endmodule // li_charge_seq_tb_top
